// *** hw/pisoreader_device.sv ***
// Device end: eight-stage capture and shift register clocked from sampled link pins.
//
// Overview of operation
// - Strobe low copies field inputs into stages.
// - Strobe high freezes stages against field inputs.
// - Shifting only while shift gate low.
// - Shift on shift clock rising edge only.
// - After eight shifts, serial input appears.
// - Chain serial output into next serial input.
// - Host pairs adjacent bits as one channel.
// - Serial input loads into first stage.
// - Shift needs strobe high, gate low, edge.
// - Strobe low overrides clock, gate, serial input.
module pisoreader_device
    import pisoreader_pkg::*;
(
    input  wire logic                   CORE_CLK_IN,
    input  wire logic                   RESETN_IN,
    pisoreader_if.device_mp             link,
    input  wire logic [STAGE_COUNT-1:0] FIELD_INPUTS_IN,
    output logic      [STAGE_COUNT-1:0] STAGES_OUT
);
    typedef struct packed {
        logic [1:0]             strobe_n_sync;
        logic [1:0]             gate_n_sync;
        logic [1:0]             sclk_sync;
        logic [1:0]             sin_sync;
        logic                   sclk_prev;
        logic [STAGE_COUNT-1:0] field_sync1;
        logic [STAGE_COUNT-1:0] field_sync2;
        logic [STAGE_COUNT-1:0] stages;
    } dev_state_t;

    dev_state_t st_q;
    dev_state_t st_d;
    logic       sclk_rise;

    // Edges are found on the synchronised copy, so the link clock must stay slow.
    assign sclk_rise = st_q.sclk_sync[1] & ~st_q.sclk_prev;

    always_comb begin
        st_d               = st_q;
        st_d.strobe_n_sync = {st_q.strobe_n_sync[0], link.capture_strobe_n};
        st_d.gate_n_sync   = {st_q.gate_n_sync[0], link.shift_gate_n};
        st_d.sclk_sync     = {st_q.sclk_sync[0], link.shift_clk};
        st_d.sin_sync      = {st_q.sin_sync[0], link.serial_in};
        st_d.field_sync1   = FIELD_INPUTS_IN;
        st_d.field_sync2   = st_q.field_sync1;
        st_d.sclk_prev     = st_q.sclk_sync[1];
        if (!st_q.strobe_n_sync[1]) begin
            st_d.stages = st_q.field_sync2;
        end else if (!st_q.gate_n_sync[1] && sclk_rise) begin
            st_d.stages = {st_q.stages[LAST_STAGE-1:0], st_q.sin_sync[1]};
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            st_q               <= '0;
            st_q.strobe_n_sync <= 2'h3;
            st_q.gate_n_sync   <= 2'h3;
            st_q.stages        <= STAGES_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign link.serial_out = st_q.stages[LAST_STAGE];
    assign STAGES_OUT      = st_q.stages;
endmodule

// *** hw/pisoreader_host.sv ***
// Host end: issues capture, generates shift clock, collects a frame.
module pisoreader_host
    import pisoreader_pkg::*;
(
    input  wire logic                  CORE_CLK_IN,
    input  wire logic                  RESETN_IN,
    pisoreader_if.host_mp              link,
    input  wire logic                  START_IN,
    output logic                       BUSY_OUT,
    output logic                       DONE_OUT,
    output logic [FRAME_BITS-1:0]      FRAME_OUT,
    output logic [CHANNEL_PAIRS-1:0]   PAIRED_OUT
);
    typedef struct packed {
        host_state_t           state;
        logic [DIV_W-1:0]      div;
        logic [CNT_W-1:0]      bits;
        logic [1:0]            sout_sync;
        logic [FRAME_BITS-1:0] shreg;
        logic [FRAME_BITS-1:0] frame;
        logic                  done;
        logic                  strobe_n;
        logic                  gate_n;
        logic                  sclk;
    } host_st_t;

    host_st_t st_q;
    host_st_t st_d;
    logic     tick;

    assign tick = (st_q.div == DIV_W'(SCK_HALF_DIV - 1));

    always_comb begin
        st_d           = st_q;
        st_d.done      = 1'b0;
        st_d.sout_sync = {st_q.sout_sync[0], link.serial_out};
        st_d.div       = tick ? '0 : st_q.div + DIV_W'(1);
        if (st_q.state == HS_IDLE) begin
            st_d.div = '0;
        end
        unique case (st_q.state)
            HS_IDLE: begin
                if (START_IN) begin
                    st_d.state    = HS_CAPTURE;
                    st_d.strobe_n = 1'b0;
                end
            end
            HS_CAPTURE: begin
                // Strobe low long enough for the device's sync chain.
                if (tick) begin
                    st_d.strobe_n = 1'b1;
                    st_d.state    = HS_SETUP;
                    st_d.bits     = '0;
                end
            end
            HS_SETUP: begin
                // Gate low before and during every edge.
                if (tick) begin
                    st_d.gate_n = 1'b0;
                    st_d.state  = HS_LOW;
                end
            end
            HS_LOW: begin
                // Sample before the rising edge, the bit has been stable half a period.
                if (tick) begin
                    st_d.shreg = {st_q.shreg[FRAME_BITS-2:0], st_q.sout_sync[1]};
                    st_d.sclk  = 1'b1;
                    st_d.bits  = st_q.bits + CNT_W'(1);
                    st_d.state = HS_HIGH;
                end
            end
            HS_HIGH: begin
                if (tick) begin
                    st_d.sclk = 1'b0;
                    st_d.state = (st_q.bits == CNT_W'(FRAME_BITS)) ? HS_DONE : HS_LOW;
                end
            end
            HS_DONE: begin
                st_d.gate_n = 1'b1;
                st_d.frame  = st_q.shreg;
                st_d.done   = 1'b1;
                st_d.state  = HS_IDLE;
            end
            default: st_d.state = HS_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            st_q          <= '0;
            st_q.state    <= HS_IDLE;
            st_q.shreg    <= FRAME_RESET;
            st_q.frame    <= FRAME_RESET;
            st_q.strobe_n <= 1'b1;
            st_q.gate_n   <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Adjacent bit pairs form one channel.
    generate
        for (genvar i = 0; i < CHANNEL_PAIRS; i++) begin : g_pair
            assign PAIRED_OUT[i] = st_q.frame[2*i] | st_q.frame[2*i+1];
        end
    endgenerate

    assign link.capture_strobe_n = st_q.strobe_n;
    assign link.shift_gate_n     = st_q.gate_n;
    assign link.shift_clk        = st_q.sclk;
    assign link.serial_in        = 1'b0;
    assign BUSY_OUT              = (st_q.state != HS_IDLE);
    assign DONE_OUT              = st_q.done;
    assign FRAME_OUT             = st_q.frame;
endmodule

// *** hw/pisoreader_if.sv ***
// Link between the shift-register device end and the host end.
interface pisoreader_if;
    logic capture_strobe_n;
    logic shift_gate_n;
    logic shift_clk;
    logic serial_out;
    logic serial_in;

    modport device_mp (
        input  capture_strobe_n,
        input  shift_gate_n,
        input  shift_clk,
        input  serial_in,
        output serial_out
    );
    modport host_mp (
        output capture_strobe_n,
        output shift_gate_n,
        output shift_clk,
        output serial_in,
        input  serial_out
    );
endinterface

// *** hw/pisoreader_pkg.sv ***
// Shared constants and types for the parallel-in serial-out reader link.
package pisoreader_pkg;
    localparam int unsigned STAGE_COUNT    = 8;
    localparam int unsigned LAST_STAGE     = STAGE_COUNT - 1;
    localparam int unsigned CHAIN_DEVICES  = 1;
    localparam int unsigned FRAME_BITS     = STAGE_COUNT * CHAIN_DEVICES;
    localparam int unsigned CNT_W          = $clog2(FRAME_BITS + 1);
    localparam int unsigned SCK_HALF_DIV   = 4;
    localparam int unsigned DIV_W          = $clog2(SCK_HALF_DIV + 1);
    localparam int unsigned CHANNEL_PAIRS  = STAGE_COUNT / 2;
    localparam logic [STAGE_COUNT-1:0] STAGES_RESET = 8'h00;
    localparam logic [FRAME_BITS-1:0]  FRAME_RESET  = '0;

    typedef enum logic [2:0] {
        HS_IDLE    = 3'b000,
        HS_CAPTURE = 3'b001,
        HS_SETUP   = 3'b010,
        HS_HIGH    = 3'b011,
        HS_LOW     = 3'b100,
        HS_DONE    = 3'b101
    } host_state_t;
endpackage

// *** tb/pisoreader_checker.sv ***
// Link assertions between the device and host ends.
module pisoreader_checker (
    input wire logic CORE_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic capture_strobe_n,
    input wire logic shift_gate_n,
    input wire logic shift_clk,
    input wire logic serial_out,
    input wire logic serial_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_q;
    logic [3:0] edges_q;
    default clocking dc @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    // Edges are counted per gate window, so a lost or extra edge shows at gate close.
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            clk_q   <= 1'b0;
            edges_q <= 4'h0;
        end else begin
            clk_q   <= shift_clk;
            edges_q <= shift_gate_n ? 4'h0 : edges_q + 4'(shift_clk & ~clk_q);
        end
    end
    AST_HOLD: assert property ($changed(serial_out) |->
        !$past(capture_strobe_n, 3) || !$past(shift_gate_n, 3)) else $error("output moved idle");
    AST_NO_FALL: assert property ($fell(shift_clk) |-> ##1 $stable(serial_out)[*4])
        else $error("output moved after falling edge");
    AST_ORDER: assert property (capture_strobe_n || shift_gate_n)
        else $error("strobe and gate low together");
    AST_GATED: assert property ($changed(shift_clk) |-> !shift_gate_n)
        else $error("clock moved with gate shut");
    AST_HIGH: assert property ($rose(shift_clk) |-> shift_clk[*4] ##1 !shift_clk)
        else $error("clock high time wrong");
    AST_STROBE: assert property ($fell(capture_strobe_n) |->
        !capture_strobe_n[*4] ##1 capture_strobe_n) else $error("strobe width wrong");
    AST_SETUP: assert property ($fell(shift_gate_n) |-> !shift_clk[*3])
        else $error("clock rose too soon after gate");
    AST_EIGHT: assert property ($rose(shift_gate_n) |-> edges_q == 4'h8)
        else $error("frame edge count wrong");
    cover property ($fell(capture_strobe_n));
    cover property ($rose(shift_gate_n) && edges_q == 4'h8);
    cover property ($changed(serial_out) && !serial_in);
endmodule

// *** tb/tb_top.sv ***
// Testbench joining the device and host ends of the reader link.
module tb_top
    import pisoreader_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                     clk = 1'b0;
    logic                     rst_n = 1'b0;
    logic                     start = 1'b0;
    logic [STAGE_COUNT-1:0]   field = 8'h00;
    logic                     busy, done;
    logic [FRAME_BITS-1:0]    frame;
    logic [CHANNEL_PAIRS-1:0] paired;
    logic [STAGE_COUNT-1:0]   stages;
    int                       n_errors = 0;
    int                       compares = 0;
    pisoreader_if link ();
    always #25 clk = ~clk;
    pisoreader_device u_pisoreader_device (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .link(link),
        .FIELD_INPUTS_IN(field), .STAGES_OUT(stages));
    pisoreader_host u_pisoreader_host (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .link(link),
        .START_IN(start), .BUSY_OUT(busy), .DONE_OUT(done), .FRAME_OUT(frame),
        .PAIRED_OUT(paired));
    pisoreader_checker u_pisoreader_checker (.CORE_CLK_IN(clk), .RESETN_IN(rst_n),
        .capture_strobe_n(link.capture_strobe_n), .shift_gate_n(link.shift_gate_n),
        .shift_clk(link.shift_clk), .serial_out(link.serial_out), .serial_in(link.serial_in));
    task automatic print_verdict();
        $display("Mismatches %0d, compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run_frame(input logic [7:0] cap, input logic [7:0] late);
        int i;
        logic [3:0] pairs;
        for (i = 0; i < 4; i++) pairs[i] = cap[2*i] | cap[2*i+1];
        @(posedge clk) field <= cap;
        repeat (4) @(posedge clk);
        start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        for (i = 0; i < 100 && link.shift_gate_n !== 1'b0; i++) @(posedge clk);
        // A stuck host counts as one mismatch and the frame is abandoned.
        if (link.shift_gate_n !== 1'b0) begin
            n_errors++;
            $display("CHECK FAILED gate low expected 0 seen %b", link.shift_gate_n);
            return;
        end
        // Field moves after capture; the snapshot must not follow it.
        field <= late;
        check("busy in frame", 8'h01, {7'h0, busy});
        for (i = 0; i < 400 && done !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (done !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED done expected 1 seen %b", done);
            return;
        end
        check("frame", cap, frame);
        check("paired", {4'h0, pairs}, {4'h0, paired});
        check("stages", 8'h00, stages);
        check("chain output", {7'h0, link.serial_in}, {7'h0, link.serial_out});
        check("busy after frame", 8'h00, {7'h0, busy});
    endtask
    task automatic sc_patterns();
        logic [7:0] pats [5] = '{8'ha5, 8'h80, 8'h01, 8'h3c, 8'hff};
        foreach (pats[k]) run_frame(pats[k], pats[k]);
    endtask
    task automatic sc_freeze();
        run_frame(8'h5a, 8'ha5);
        run_frame(8'h00, 8'hff);
    endtask
    task automatic sc_idle();
        @(posedge clk) field <= 8'h99;
        repeat (30) @(posedge clk);
        check("idle stages", 8'h00, stages);
        check("idle output", 8'h00, {7'h0, link.serial_out});
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        sc_patterns();
        sc_freeze();
        sc_idle();
        print_verdict();
    end
endmodule
